// ### host_bus_model.sv
`timescale 1ns/1ns
module host_bus_model
(
  input wire logic mclk,
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] host_addr_lo
);
  // ----------------------------------------
  // Host processor side of the parallel bus
  // ----------------------------------------

  // The bus rests deselected with both strobes high.
  initial
  begin
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_addr_lo = 4'h0;
  end

  // Starts a cycle just after an edge and holds it until the next call.
  task automatic drive(input logic a_n, input logic b_n, input logic rd_n,
                       input logic wr_n, input logic [3:0] ad);
    @(posedge mclk);
    chan_a_select_n <= a_n;
    chan_b_select_n <= b_n;
    // A read is never issued with both channels selected.
    read_strobe_n <= rd_n | (~a_n & ~b_n);
    write_strobe_n <= wr_n;
    host_addr_lo <= ad;
  endtask
endmodule

// ### irda_codec.sv
`timescale 1ns/1ns
`include "uart_line_cfg.svh"
module irda_codec
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ir_en,
  input wire logic ir_fast,
  input wire logic tick16,
  input wire logic bit_start,
  input wire logic tx_bit,
  input wire logic rx_level,
  output logic tx_line_r,
  output logic rx_stream_r
);
  logic [4:0] enc_cnt_r;
  logic [4:0] enc_nxt;
  logic [4:0] dec_cnt_r;
  logic [4:0] dec_nxt;
  logic rx_prev_r;
  logic rx_edge;

  // Counts down one 16x tick at a time.
  function automatic logic [4:0] tick_down(input logic [4:0] cnt,
                                           input logic tick);
    tick_down = (tick && cnt != 5'h00) ? cnt - 5'h01 : cnt;
  endfunction

  // ----------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------
  // A 0 bit starts a high pulse of 3 or 4 ticks; a 1 bit leaves it low.
  always_comb
  begin
    enc_nxt = tick_down(enc_cnt_r, tick16);
    if (bit_start && ir_en && !tx_bit)
    begin
      enc_nxt = ir_fast ? `IR_FAST_TICKS : `IR_SLOW_TICKS;
    end
  end

  // Pulse counter.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      enc_cnt_r <= 5'h00;
    else
      enc_cnt_r <= enc_nxt;
  end

  // In infrared mode the line idles low and only pulses go high.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tx_line_r <= 1'b1;
    else if (ir_en)
      tx_line_r <= (enc_nxt != 5'h00);
    else
      tx_line_r <= tx_bit;
  end

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  // A rising edge on the idle-low input marks a light pulse.
  assign rx_edge = rx_level && !rx_prev_r;

  // Each pulse holds a 1 in the stream for one bit time.
  always_comb
  begin
    dec_nxt = tick_down(dec_cnt_r, tick16);
    if (rx_edge)
    begin
      dec_nxt = `IR_BIT_TICKS;
    end
  end

  // Decoder state.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_prev_r <= 1'b0;
      dec_cnt_r <= 5'h00;
      rx_stream_r <= 1'b0;
    end
    else
    begin
      rx_prev_r <= rx_level;
      dec_cnt_r <= dec_nxt;
      rx_stream_r <= ir_en ? (dec_nxt != 5'h00) : rx_level;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ir_slow_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ir_en && !ir_fast && bit_start && !tx_bit)
      |=> (enc_cnt_r == `IR_SLOW_TICKS) && tx_line_r)
    else $error("slow infrared pulse width wrong");

  ir_fast_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ir_en && ir_fast && bit_start && !tx_bit)
      |=> (enc_cnt_r == `IR_FAST_TICKS))
    else $error("fast infrared pulse width wrong");

  ir_idle_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ir_en && enc_cnt_r == 5'h00 && !(bit_start && !tx_bit))
      |=> !tx_line_r)
    else $error("infrared output not idling low");

  ir_rx_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ir_en && rx_edge) |=> rx_stream_r [*2])
    else $error("light pulse did not return a one");
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic mclk, rst_n, flow_rts_n, tx_push, tx_fifo_empty, tx_done, tx_tick16;
  logic tx_bit_start, tx_bit, rx_word_valid, host_rcv_enable;
  logic host_rcv_disable, bus_style_split, rx_pin, a_n, b_n, rd_n, wr_n;
  logic [7:0] ext_div, modem_ctl, feat_ctl, int_en, mdc, aux_ctl, station_id;
  logic [3:0] addr;
  logic [1:0] tk = 2'h0;
  logic rts, txl, rxs, push, irq, rcv_on, sa, sb;
  uart_line_pkg::rx_word_t rx_word;
  uart_line_pkg::rx_char_t rchar;
  uart_line_pkg::host_sel_t hsel;
  int bad_count, total_checks, cyc, i, s, n;

  uart_line_features dut_u (.mclk(mclk), .rst_n(rst_n),
    .divisor_extension_reg(ext_div), .modem_control_reg(modem_ctl),
    .enhanced_feature_reg(feat_ctl), .interrupt_enable_reg(int_en),
    .multidrop_control_reg(mdc), .auxiliary_setup_reg(aux_ctl),
    .second_flow_stop_char(station_id), .flow_rts_n(flow_rts_n),
    .tx_push(tx_push), .tx_fifo_empty(tx_fifo_empty), .tx_done(tx_done),
    .tx_tick16(tx_tick16), .tx_bit_start(tx_bit_start), .tx_bit(tx_bit),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .host_rcv_enable(host_rcv_enable), .host_rcv_disable(host_rcv_disable),
    .bus_style_split(bus_style_split), .chan_a_select_n(a_n),
    .chan_b_select_n(b_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .host_addr_lo(addr), .rx_pin(rx_pin), .rts_pin_r(rts), .tx_line(txl),
    .rx_stream(rxs), .rx_push_r(push), .rx_char_r(rchar),
    .line_irq_r(irq), .rcv_on_r(rcv_on), .host_sel_r(hsel));

  host_bus_model host_u (.mclk(mclk), .chan_a_select_n(a_n),
    .chan_b_select_n(b_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .host_addr_lo(addr));

  // ----------------------------------------
  // Clock, baud ticks and hang guard
  // ----------------------------------------

  // The clock toggles every 25 ns.
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // A 16x tick on every fourth rising edge; the run is cut short if it hangs.
  always @(posedge mclk)
  begin
    tk <= tk + 2'h1;
    tx_tick16 <= (tk == 2'h3);
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic chk9(input logic [8:0] got, input logic [8:0] exp,
                      input string m);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // Sends one received character and checks what the filter makes of it.
  task automatic rx_case(input logic nb, input logic [7:0] d,
                         input logic ep, input logic ei, input logic eon);
    @(posedge mclk);
    rx_word_valid <= 1'b1;
    rx_word <= {nb, d};
    step(1);
    rx_word_valid <= 1'b0;
    chk1(push, ep, "rx push");
    if (ep)
      chk9(rchar, {nb, d}, "rx char");
    chk1(irq, ei, "line irq");
    chk1(rcv_on, eon, "receiver on");
  endtask

  // Host turns the receiver on or off with a one-cycle pulse.
  task automatic host_pulse(input logic en);
    @(posedge mclk);
    host_rcv_enable <= en;
    host_rcv_disable <= ~en;
    step(1);
    host_rcv_enable <= 1'b0;
    host_rcv_disable <= 1'b0;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------

  // Reset, then each feature in turn.
  initial
  begin
    {rst_n, flow_rts_n, tx_push, tx_done, tx_bit_start} = 5'h00;
    {rx_word_valid, host_rcv_enable, host_rcv_disable, rx_pin} = 4'h0;
    {tx_fifo_empty, tx_bit, bus_style_split} = 3'h7;
    {ext_div, modem_ctl, feat_ctl, int_en, mdc, aux_ctl, station_id} = '0;
    rx_word = '0;
    {bad_count, total_checks} = '0;
    step(12);
    chk9({rts, txl, rxs, push, irq, rcv_on, 3'h0}, 9'h180, "reset outs");
    chk1(|hsel, 1'b0, "reset sel");
    @(posedge mclk);
    rst_n <= 1'b1;
    // Channel decode in both bus styles.
    for (s = 0; s < 2; s++)
      for (i = 0; i < 8; i++)
      begin
        @(posedge mclk);
        bus_style_split <= (s == 0);
        // The channel B select pin rests high in the shared-select style.
        host_u.drive(i[0], s ? 1'b1 : i[1], i[2], ~i[2], {i[1], 3'h5});
        step(4);
        sa = s ? (~i[0] & ~i[1]) : ~i[0];
        sb = s ? (~i[0] & i[1]) : ~i[1];
        n = (~i[2] && (sa && sb)) ? 0 : 1;
        chk9(hsel, {5'h0, sa, sb, ~i[2] & (sa | sb) & n[0],
                    i[2] & (sa | sb)}, "channel decode");
      end
    // Direction pin under modem control and flow control.
    @(posedge mclk);
    modem_ctl <= 8'h02;
    step(4);
    chk1(rts, 1'b0, "rts modem bit");
    @(posedge mclk);
    feat_ctl <= 8'h40;
    flow_rts_n <= 1'b1;
    step(4);
    chk1(rts, 1'b1, "rts flow");
    // Flow control goes off in the same cycle that the transmitter takes the pin,
    // and the modem-control bit, which would drive it high, is ignored.
    for (s = 0; s < 2; s++)
    begin
      @(posedge mclk);
      ext_div <= 8'h40;
      feat_ctl <= 8'h00;
      modem_ctl <= 8'h00;
      mdc <= s ? 8'h20 : 8'h00;
      step(4);
      chk1(rts, s[0], "rts auto idle");
      @(posedge mclk);
      tx_push <= 1'b1;
      tx_fifo_empty <= 1'b0;
      step(1);
      tx_push <= 1'b0;
      chk1(rts, ~s[0], "rts on push");
      step(6);
      chk1(rts, ~s[0], "rts while sending");
      @(posedge mclk);
      tx_done <= 1'b1;
      tx_fifo_empty <= 1'b1;
      step(1);
      tx_done <= 1'b0;
      step(1);
      chk1(rts, s[0], "rts after stop bit");
    end
    // Inversion has no effect outside auto mode.
    @(posedge mclk);
    {ext_div, feat_ctl, modem_ctl} <= '0;
    step(4);
    chk1(rts, 1'b1, "rts no invert");
    // Outside 9-bit mode even a marked character is stored as it is.
    rx_case(1'b1, 8'h3c, 1'b1, 1'b0, 1'b0);
    // Plain multidrop with host-driven receiver; line interrupt enabled,
    // and the ninth bit carries the address mark.
    @(posedge mclk);
    {mdc, int_en} <= {8'h01, 8'h04};
    rx_case(1'b0, 8'h11, 1'b0, 1'b0, 1'b0);
    rx_case(1'b1, 8'ha5, 1'b1, 1'b1, 1'b0);
    host_pulse(1'b1);
    rx_case(1'b0, 8'h22, 1'b1, 1'b0, 1'b1);
    rx_case(1'b1, 8'h77, 1'b1, 1'b1, 1'b1);
    host_pulse(1'b0);
    rx_case(1'b0, 8'h33, 1'b0, 1'b0, 1'b0);
    // Auto address detection, line interrupt masked once.
    @(posedge mclk);
    {feat_ctl, station_id, int_en} <= {8'h20, 8'h5a, 8'h00};
    rx_case(1'b0, 8'h44, 1'b0, 1'b0, 1'b0);
    rx_case(1'b1, 8'h33, 1'b0, 1'b0, 1'b0);
    rx_case(1'b1, 8'h5a, 1'b1, 1'b0, 1'b1);
    @(posedge mclk);
    int_en <= 8'h04;
    rx_case(1'b0, 8'h66, 1'b1, 1'b0, 1'b1);
    rx_case(1'b1, 8'h5a, 1'b1, 1'b1, 1'b1);
    rx_case(1'b1, 8'h33, 1'b0, 1'b0, 1'b0);
    // Infrared encoder: pulse width for both standards.
    for (s = 0; s < 2; s++)
    begin
      @(posedge mclk);
      {ext_div, aux_ctl} <= {8'h80, s ? 8'h10 : 8'h00};
      step(8);
      chk1(txl, 1'b0, "ir tx idle");
      @(posedge mclk iff tk == 2'h3);
      tx_bit_start <= 1'b1;
      tx_bit <= 1'b0;
      n = 0;
      repeat (60)
      begin
        @(posedge mclk);
        tx_bit_start <= 1'b0;
        #1;
        n += txl;
      end
      tx_bit <= 1'b1;
      chk1(n >= (3 + s) * 4 && n <= (3 + s) * 4 + 1, 1'b1,
           "ir pulse width");
    end
    // Infrared decoder: a light pulse yields a one.
    step(8);
    chk1(rxs, 1'b0, "ir rx idle");
    @(posedge mclk);
    rx_pin <= 1'b1;
    step(2);
    rx_pin <= 1'b0;
    step(8);
    chk1(rxs, 1'b1, "ir rx pulse");
    report_and_stop();
  end
endmodule

// ### uart_line_cfg.svh
`ifndef UART_LINE_CFG_SVH
`define UART_LINE_CFG_SVH
// What this block does
// - Divisor extension bit 6 hands the RTS pin to the transmitter.
// - Auto direction: RTS goes 1 on a host write, 0 after the last bit.
// - Multidrop control bit 5 inverts RTS, only in auto direction mode.
// - Multidrop control bit 0 enables 9-bit mode; parity 1 marks an address.
// - Plain multidrop: a disabled receiver drops data until the host enables it.
// - An address byte flags parity error, is stored, may raise line interrupt.
// - Enabled receiver keeps taking data; next address flags parity again.
// - Auto address mode drops data and non-matching addresses while off.
// - Matching address turns receiver on, is stored, may raise line interrupt.
// - Auto address mode: a non-matching address turns receiver off, unstored, unless the host enables it in that cycle.
// - Host port: 4 address lines, strobed asynchronous cycles.
// - First bus style: active-low selects; both low selects both channels.
// - Second bus style: one select, address line 3 picks the channel.
// - Infrared mode sends a 3/16-bit high pulse for each 0 bit.
// - Auxiliary bit 4 makes the pulse a quarter bit instead.
// - Divisor extension bit 7 enables infrared; line idles low then.
// - The infrared decoder returns a 1 for each detected light pulse.

// Control bit positions.
`define DIVX_AUTO_RTS_BIT 6
`define DIVX_IR_EN_BIT 7
`define MODEM_RTS_BIT 1
`define MDC_9BIT_BIT 0
`define MDC_RTS_INV_BIT 5
`define FEAT_ADDR_DET_BIT 5
`define FEAT_HW_RTS_BIT 6
`define INTEN_LINE_BIT 2
`define AUX_IR_FAST_BIT 4
`define CHAN_ADDR_BIT 3

// Infrared timing in 16x baud ticks.
`define IR_SLOW_TICKS 5'h03
`define IR_FAST_TICKS 5'h04
`define IR_BIT_TICKS 5'h10

// Reset values.
`define RTS_PIN_RST 1'b1
`define PIN_SYNC_RST 10'h3e0
`endif

// ### uart_line_features.sv
`timescale 1ns/1ns
`include "uart_line_cfg.svh"
module uart_line_features
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] divisor_extension_reg,
  input wire logic [7:0] modem_control_reg,
  input wire logic [7:0] enhanced_feature_reg,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [7:0] multidrop_control_reg,
  input wire logic [7:0] auxiliary_setup_reg,
  input wire logic [7:0] second_flow_stop_char,
  input wire logic flow_rts_n,
  input wire logic tx_push,
  input wire logic tx_fifo_empty,
  input wire logic tx_done,
  input wire logic tx_tick16,
  input wire logic tx_bit_start,
  input wire logic tx_bit,
  input wire logic rx_word_valid,
  input wire uart_line_pkg::rx_word_t rx_word,
  input wire logic host_rcv_enable,
  input wire logic host_rcv_disable,
  input wire logic bus_style_split,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] host_addr_lo,
  input wire logic rx_pin,
  output logic rts_pin_r,
  output logic tx_line,
  output logic rx_stream,
  output logic rx_push_r,
  output uart_line_pkg::rx_char_t rx_char_r,
  output logic line_irq_r,
  output logic rcv_on_r,
  output uart_line_pkg::host_sel_t host_sel_r
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [9:0] pin_s1_r;
  logic [9:0] pin_s2_r;
  logic style_split;
  logic sel_a_n;
  logic sel_b_n;
  logic rd_n;
  logic wr_n;
  logic chan_bit;
  logic rx_level;
  uart_line_pkg::host_sel_t sel_nxt;
  uart_line_pkg::dir_state_t dir_state_r;
  uart_line_pkg::dir_state_t dir_nxt;
  logic auto_dir;
  logic rts_inv;
  logic rts_nxt;
  logic mdrop;
  logic auto_addr;
  logic addr_match;
  logic push_nxt;
  logic irq_nxt;
  logic rcv_set;
  logic rcv_clr;

  // Control bits picked out of the configuration inputs.
  assign auto_dir = divisor_extension_reg[`DIVX_AUTO_RTS_BIT];
  assign rts_inv = multidrop_control_reg[`MDC_RTS_INV_BIT];
  assign mdrop = multidrop_control_reg[`MDC_9BIT_BIT];
  assign auto_addr = enhanced_feature_reg[`FEAT_ADDR_DET_BIT];
  assign addr_match = (rx_word.data == second_flow_stop_char);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Host pins and the serial input are not tied to mclk, so each one
  // passes two flops before anything looks at it.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= `PIN_SYNC_RST;
      pin_s2_r <= `PIN_SYNC_RST;
    end
    else
    begin
      pin_s1_r <= {bus_style_split, chan_a_select_n, chan_b_select_n,
                   read_strobe_n, write_strobe_n, host_addr_lo, rx_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Names for the synchronised pins.
  assign style_split = pin_s2_r[9];
  assign sel_a_n = pin_s2_r[8];
  assign sel_b_n = pin_s2_r[7];
  assign rd_n = pin_s2_r[6];
  assign wr_n = pin_s2_r[5];
  assign chan_bit = pin_s2_r[1 + `CHAN_ADDR_BIT];
  assign rx_level = pin_s2_r[0];

  // ----------------------------------------------------------------
  // Host channel select
  // ----------------------------------------------------------------
  // The first bus style uses one select per channel; the second uses
  // the first select pin as a shared select and address bit 3 as the
  // channel choice. Strobes count only while a channel is selected.
  always_comb
  begin
    sel_nxt = '0;
    if (style_split)
    begin
      sel_nxt.chan_a = !sel_a_n;
      sel_nxt.chan_b = !sel_b_n;
    end
    else if (!sel_a_n)
    begin
      sel_nxt.chan_a = !chan_bit;
      sel_nxt.chan_b = chan_bit;
    end
    sel_nxt.rd = (sel_nxt.chan_a || sel_nxt.chan_b) && !rd_n;
    sel_nxt.wr = (sel_nxt.chan_a || sel_nxt.chan_b) && !wr_n;
  end

  // Registered select outputs.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      host_sel_r <= '0;
    else
      host_sel_r <= sel_nxt;
  end

  // ----------------------------------------------------------------
  // Transmit direction control
  // ----------------------------------------------------------------
  // A host write opens the send window; it closes only once the stop
  // bit is out, the shifter is empty and nothing is left queued. A
  // write in the closing cycle keeps the window open.
  always_comb
  begin
    dir_nxt = dir_state_r;
    case (dir_state_r)
      uart_line_pkg::DIR_IDLE:
      begin
        if (tx_push)
          dir_nxt = uart_line_pkg::DIR_SEND;
      end
      uart_line_pkg::DIR_SEND:
      begin
        if (tx_done && tx_fifo_empty && !tx_push)
          dir_nxt = uart_line_pkg::DIR_IDLE;
      end
      default:
      begin
        dir_nxt = uart_line_pkg::DIR_IDLE;
      end
    endcase
  end

  // Direction state.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dir_state_r <= uart_line_pkg::DIR_IDLE;
    else
      dir_state_r <= dir_nxt;
  end

  // Auto direction outranks flow control and the modem-control bit;
  // inversion applies only in auto direction mode.
  always_comb
  begin
    if (auto_dir)
      rts_nxt = (dir_nxt == uart_line_pkg::DIR_SEND) ^ rts_inv;
    else if (enhanced_feature_reg[`FEAT_HW_RTS_BIT])
      rts_nxt = flow_rts_n;
    else
      rts_nxt = !modem_control_reg[`MODEM_RTS_BIT];
  end

  // RTS pin flop.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rts_pin_r <= `RTS_PIN_RST;
    else
      rts_pin_r <= rts_nxt;
  end

  // ----------------------------------------------------------------
  // Multidrop receive filter
  // ----------------------------------------------------------------
  // Outside 9-bit mode every character goes through. In 9-bit mode a
  // ninth bit of 1 marks an address. Plain mode stores every address
  // and stores data only while the receiver is on. Auto address mode
  // stores only matching addresses, switching the receiver itself.
  always_comb
  begin
    push_nxt = 1'b0;
    irq_nxt = 1'b0;
    rcv_set = 1'b0;
    rcv_clr = 1'b0;
    if (rx_word_valid)
    begin
      if (!mdrop)
        push_nxt = 1'b1;
      else if (rx_word.ninth && !auto_addr)
      begin
        push_nxt = 1'b1;
        irq_nxt = interrupt_enable_reg[`INTEN_LINE_BIT];
      end
      else if (rx_word.ninth && addr_match)
      begin
        push_nxt = 1'b1;
        irq_nxt = interrupt_enable_reg[`INTEN_LINE_BIT];
        rcv_set = 1'b1;
      end
      else if (rx_word.ninth)
        rcv_clr = 1'b1;
      else
        push_nxt = rcv_on_r;
    end
  end

  // Receiver on/off: hardware turn-on wins over a host turn-off.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rcv_on_r <= 1'b0;
    else if (rcv_set || host_rcv_enable)
      rcv_on_r <= 1'b1;
    else if (rcv_clr || host_rcv_disable)
      rcv_on_r <= 1'b0;
  end

  // Stored character; the ninth bit rides in the parity-error place.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_push_r <= 1'b0;
      rx_char_r <= '0;
      line_irq_r <= 1'b0;
    end
    else
    begin
      rx_push_r <= push_nxt;
      rx_char_r <= {rx_word.ninth, rx_word.data};
      line_irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Infrared codec
  // ----------------------------------------------------------------
  irda_codec u_irda
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .ir_en(divisor_extension_reg[`DIVX_IR_EN_BIT]),
    .ir_fast(auxiliary_setup_reg[`AUX_IR_FAST_BIT]),
    .tick16(tx_tick16),
    .bit_start(tx_bit_start),
    .tx_bit(tx_bit),
    .rx_level(rx_level),
    .tx_line_r(tx_line),
    .rx_stream_r(rx_stream)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  rts_auto_own_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(auto_dir) && !$past(rts_inv))
      |-> rts_pin_r == (dir_state_r == uart_line_pkg::DIR_SEND))
    else $error("RTS does not follow the transmitter");

  rts_on_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (auto_dir && !rts_inv && tx_push) ##1 (auto_dir && !rts_inv)
      |-> rts_pin_r)
    else $error("RTS not raised after a host write");

  rts_invert_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(auto_dir) && $past(rts_inv))
      |-> rts_pin_r != (dir_state_r == uart_line_pkg::DIR_SEND))
    else $error("RTS inversion wrong");

  dir_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (dir_state_r == uart_line_pkg::DIR_SEND && !(tx_done && tx_fifo_empty))
      |=> dir_state_r == uart_line_pkg::DIR_SEND)
    else $error("direction dropped before the stop bit");

  drop_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mdrop && !rcv_on_r && rx_word_valid && !rx_word.ninth) |=> !rx_push_r)
    else $error("data stored while receiver off");

  addr_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mdrop && !auto_addr && rx_word_valid && rx_word.ninth)
      |=> rx_push_r && rx_char_r.perr
          && line_irq_r == $past(interrupt_enable_reg[`INTEN_LINE_BIT]))
    else $error("address byte not stored with parity flag");

  match_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mdrop && auto_addr && rx_word_valid && rx_word.ninth && addr_match)
      |=> rx_push_r && rcv_on_r && rx_char_r.perr)
    else $error("matching address not taken");

  miss_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mdrop && auto_addr && rx_word_valid && rx_word.ninth && !addr_match
     && !host_rcv_enable) |=> !rx_push_r && !rcv_on_r)
    else $error("non-matching address not rejected");

  sel_both_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (style_split && !sel_a_n && !sel_b_n)
      |=> host_sel_r.chan_a && host_sel_r.chan_b)
    else $error("both selects low did not pick both channels");

  sel_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!style_split && !sel_a_n)
      |=> host_sel_r.chan_b == $past(chan_bit)
          && host_sel_r.chan_a != $past(chan_bit))
    else $error("address bit channel decode wrong");
endmodule

// ### uart_line_pkg.sv
package uart_line_pkg;
  typedef enum logic [1:0] {DIR_IDLE = 2'b01, DIR_SEND = 2'b10} dir_state_t;
  typedef struct packed {
    logic chan_a;
    logic chan_b;
    logic rd;
    logic wr;
  } host_sel_t;
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } rx_word_t;
  typedef struct packed {
    logic perr;
    logic [7:0] data;
  } rx_char_t;
endpackage
